// ==== rtl/tmr8_consts.vh ====
// constants for the 8-bit timer counter unit
// assumes byte-wide registers sitting in the low bits of 32-bit words
`ifndef TMR8_CONSTS_VH
`define TMR8_CONSTS_VH

`define OFS_CTRL       4'h0
`define OFS_COUNT      4'h4
`define OFS_COMPARE    4'h8
`define OFS_FLAGS      4'hc

`define CTRL_CS_LSB    0
`define CTRL_CS_MSB    2
`define CTRL_WGM_LSB   3
`define CTRL_WGM_MSB   4
`define CTRL_FORCE_BIT 5

`define FLAG_MATCH_BIT 0
`define FLAG_OVF_BIT   1

`define WGM_NORMAL     2'h0
`define WGM_PC_PWM     2'h1
`define WGM_CTC        2'h2
`define WGM_FAST_PWM   2'h3

`define CS_STOPPED     3'h0
`define CS_DIRECT      3'h1
`define CS_EXT_FALL    3'h6
`define CS_EXT_RISE    3'h7

`define BOTTOM_VAL     8'h00
`define MAX_VAL        8'hff
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ==== rtl/tick_select.v ====
// timer tick source: direct, prescaled or edge of the external input
// assumes ext_clk_i is already synchronous to core_clk_i
`timescale 1ns/100ps
`default_nettype none
`include "tmr8_consts.vh"

module tick_select (
  input  wire       core_clk_i,
  input  wire       reset_n_i,
  input  wire [2:0] clock_source_select_i,
  input  wire       ext_clk_i,
  output reg        timer_tick_o
);

  reg  [9:0] presc_q;
  reg        ext_q;
  wire [9:0] presc_d = presc_q + 10'h001;
  wire       rise    = ext_clk_i & ~ext_q;
  wire       fall    = ~ext_clk_i & ext_q;
  reg        tick_d;

  // prescaler free-runs; taps pick /8, /64, /256, /1024
  always @* begin
    case (clock_source_select_i)
      3'h1:    tick_d = 1'b1;
      3'h2:    tick_d = (presc_q[2:0] == 3'h7);
      3'h3:    tick_d = (presc_q[5:0] == 6'h3f);
      3'h4:    tick_d = (presc_q[7:0] == 8'hff);
      3'h5:    tick_d = (presc_q == 10'h3ff);
      3'h6:    tick_d = fall;
      3'h7:    tick_d = rise;
      default: tick_d = 1'b0; // see RULE9
    endcase
  end

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      presc_q      <= 10'h000;
      ext_q        <= 1'b0;
      timer_tick_o <= 1'b0;
    end else begin
      presc_q      <= presc_d;
      ext_q        <= ext_clk_i;
      timer_tick_o <= tick_d; // see RULE8
    end
  end

endmodule
`default_nettype wire

// ==== rtl/tmr8_unit.v ====
// 8-bit timer counter unit with axi4-lite register access
// assumes a single clock; external tick input synchronous to it
// Functional notes
// RULE1: 8-bit up/down counter, readable by software
// RULE2: counts step by one; clear zeroes all
// RULE3: each tick clears, increments or decrements
// RULE4: bottom indicated when counter equals zero
// RULE5: max recognised at all-ones value
// RULE6: top is all-ones or compare value
// RULE7: separate top and bottom indications
// RULE8: tick from internal or external source
// RULE9: select zero stops counting entirely
// RULE10: counter readable and writable any time
// RULE11: software write beats clear or count
// RULE12: two mode bits choose count sequence
// RULE13: compare value compared against counter continuously
// RULE14: match drives pwm or frequency output
// RULE15: match sets flag, may request interrupt
// RULE16: overflow flag set where mode defines
// RULE17: match flag set on following tick
// RULE18: counter write blocks next tick's match
// RULE19: flag cleared by writing one or service
// RULE20: compare buffered only in pwm modes
// RULE21: reset zeroes counter, compare, select, flags
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "tmr8_consts.vh"

module tmr8_unit (
  input  wire        core_clk_i,
  input  wire        reset_n_i,
  input  wire        ext_clk_i,
  input  wire        match_ack_i,
  input  wire        ovf_ack_i,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         compare_output_pin_o,
  output reg         match_irq_o,
  output reg         ovf_irq_o,
  output reg         top_o,
  output reg         bottom_o
);

  parameter WIDTH = 8;

  // fsm for the write channel, one-hot
  localparam W_IDLE = 3'b001;
  localparam W_HAVE = 3'b010;
  localparam W_RESP = 3'b100;

  function is_pwm;
    input [1:0] m;
    begin
      is_pwm = (m == `WGM_PC_PWM) || (m == `WGM_FAST_PWM);
    end
  endfunction

  function [3:0] word_ofs;
    input [31:0] a;
    begin
      word_ofs = a[3:0];
    end
  endfunction

  reg [2:0]       wst_q;
  reg [31:0]      awaddr_q;
  reg [31:0]      wdata_q;
  reg [3:0]       wstrb_q;
  reg             aw_got_q;
  reg             w_got_q;

  reg [WIDTH-1:0] counter_value_q;
  reg [WIDTH-1:0] compare_value_q;
  reg [WIDTH-1:0] compare_buf_q;
  reg [2:0]       clock_source_select_q;
  reg [1:0]       waveform_mode_select_q;
  reg             compare_match_flag_q;
  reg             overflow_flag_q;
  reg             down_q;
  reg             block_q;

  wire            timer_tick;
  wire            is_bottom = (counter_value_q == `BOTTOM_VAL); // see RULE4
  wire            is_max    = (counter_value_q == `MAX_VAL);    // see RULE5
  wire [WIDTH-1:0] top_val  =
    (waveform_mode_select_q == `WGM_CTC) ? compare_value_q
                                         : `MAX_VAL;          // see RULE6
  wire            is_top    = (counter_value_q == top_val);
  wire            cmp_eq    =
    (counter_value_q == compare_value_q);                 // see RULE13

  // commit once both halves are latched; refused addresses never alias
  wire addr_ok   = (awaddr_q[31:4] == 28'h0000000) &&
                   (awaddr_q[1:0] == 2'h0);
  wire do_write  = (wst_q == W_HAVE) & addr_ok;
  wire wr_lane0  = do_write & wstrb_q[0];
  wire wr_ctrl   = wr_lane0 & (word_ofs(awaddr_q) == `OFS_CTRL);
  wire wr_count  = wr_lane0 & (word_ofs(awaddr_q) == `OFS_COUNT);
  wire wr_cmp    = wr_lane0 & (word_ofs(awaddr_q) == `OFS_COMPARE);
  wire wr_flags  = wr_lane0 & (word_ofs(awaddr_q) == `OFS_FLAGS);
  wire force_cmp = wr_ctrl & wdata_q[`CTRL_FORCE_BIT] &
                   ~is_pwm(wdata_q[`CTRL_WGM_MSB:`CTRL_WGM_LSB]);
  wire match_hit = timer_tick & cmp_eq & ~block_q & ~wr_count; // see RULE18

  tick_select u_tick (
    .core_clk_i            (core_clk_i),
    .reset_n_i             (reset_n_i),
    .clock_source_select_i (clock_source_select_q),
    .ext_clk_i             (ext_clk_i),
    .timer_tick_o          (timer_tick)
  );

  // next counter value and direction for the active mode
  reg [WIDTH-1:0] cnt_d;
  reg             down_d;
  reg             ovf_set;
  reg             reload;
  always @* begin
    cnt_d   = counter_value_q;
    down_d  = down_q;
    ovf_set = 1'b0;
    reload  = 1'b0;
    case (waveform_mode_select_q)                 // see RULE12
      `WGM_NORMAL: begin
        cnt_d   = counter_value_q + 8'h01;        // see RULE2
        ovf_set = is_max;                         // see RULE16
        down_d  = 1'b0;
      end
      `WGM_CTC: begin
        cnt_d   = is_top ? `BOTTOM_VAL : counter_value_q + 8'h01;
        ovf_set = is_max;
        down_d  = 1'b0;
      end
      `WGM_FAST_PWM: begin
        cnt_d   = counter_value_q + 8'h01;
        ovf_set = is_max;
        reload  = is_top;
        down_d  = 1'b0;
      end
      `WGM_PC_PWM: begin
        // turn round at top and at bottom
        if (is_top) begin
          down_d = 1'b1;
        end else if (is_bottom) begin
          down_d = 1'b0;
        end
        cnt_d   = (down_d) ? counter_value_q - 8'h01
                           : counter_value_q + 8'h01; // see RULE2
        ovf_set = is_bottom & down_q;
        reload  = is_top;
      end
      default: begin
        cnt_d = counter_value_q;
      end
    endcase
  end

  // register file and counter
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      counter_value_q        <= 8'h00;  // see RULE21
      compare_value_q        <= 8'h00;
      compare_buf_q          <= 8'h00;
      clock_source_select_q  <= `CS_STOPPED;
      waveform_mode_select_q <= `WGM_NORMAL;
      compare_match_flag_q   <= 1'b0;
      overflow_flag_q        <= 1'b0;
      down_q                 <= 1'b0;
      block_q                <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        clock_source_select_q  <= wdata_q[`CTRL_CS_MSB:`CTRL_CS_LSB];
        waveform_mode_select_q <= wdata_q[`CTRL_WGM_MSB:`CTRL_WGM_LSB];
      end
      // write wins over any clear or count this cycle
      if (wr_count) begin
        counter_value_q <= wdata_q[7:0];        // see RULE10 RULE11
      end else if (timer_tick) begin
        counter_value_q <= cnt_d;               // see RULE3
        down_q          <= down_d;
      end
      // buffered compare only in pwm modes
      if (wr_cmp) begin
        compare_buf_q <= wdata_q[7:0];
      end
      if (wr_cmp & ~is_pwm(waveform_mode_select_q)) begin
        compare_value_q <= wdata_q[7:0];        // see RULE20
      end else if (timer_tick & reload) begin
        compare_value_q <= compare_buf_q;       // see RULE20
      end
      // block holds until the next tick, even when stopped
      if (wr_count) begin
        block_q <= 1'b1;                        // see RULE18
      end else if (timer_tick) begin
        block_q <= 1'b0;
      end
      // equality reached on one tick is flagged on the next; set wins
      if (match_hit) begin
        compare_match_flag_q <= 1'b1;           // see RULE15 RULE17
      end else if ((wr_flags & wdata_q[`FLAG_MATCH_BIT]) | match_ack_i) begin
        compare_match_flag_q <= 1'b0;           // see RULE19
      end
      if (timer_tick & ovf_set & ~wr_count) begin
        overflow_flag_q <= 1'b1;                // see RULE16
      end else if ((wr_flags & wdata_q[`FLAG_OVF_BIT]) | ovf_ack_i) begin
        overflow_flag_q <= 1'b0;
      end
    end
  end

  // pin, interrupt requests and status indications
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      compare_output_pin_o <= 1'b0;
      match_irq_o          <= 1'b0;
      ovf_irq_o            <= 1'b0;
      top_o                <= 1'b0;
      bottom_o             <= 1'b0;
    end else begin
      // toggles on match: frequency output in non-pwm modes, a
      // pwm edge otherwise; a pwm pin would need the compare mode bits
      if (match_hit | force_cmp) begin
        compare_output_pin_o <= ~compare_output_pin_o; // see RULE14
      end
      match_irq_o <= compare_match_flag_q;      // see RULE15
      ovf_irq_o   <= overflow_flag_q;           // see RULE16
      top_o       <= is_top;                    // see RULE7
      bottom_o    <= is_bottom;                 // see RULE7
    end
  end

  // axi4-lite write side: address and data in either order
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wst_q         <= W_IDLE;
      awaddr_q      <= 32'h00000000;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      case (wst_q)
        W_IDLE: begin
          if (s_axi_awvalid & ~aw_got_q & ~s_axi_awready) begin
            awaddr_q      <= s_axi_awaddr;
            aw_got_q      <= 1'b1;
            s_axi_awready <= 1'b1;
          end
          if (s_axi_wvalid & ~w_got_q & ~s_axi_wready) begin
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            w_got_q      <= 1'b1;
            s_axi_wready <= 1'b1;
          end
          if (aw_got_q & w_got_q) begin
            wst_q <= W_HAVE;
          end
        end
        W_HAVE: begin
          s_axi_bvalid <= 1'b1;
          s_axi_bresp  <= addr_ok ? `RESP_OKAY : `RESP_SLVERR;
          wst_q        <= W_RESP;
        end
        W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            wst_q        <= W_IDLE;
          end
        end
        default: begin
          wst_q <= W_IDLE;
        end
      endcase
    end
  end

  // axi4-lite read side; registers sit in the low byte
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    case (word_ofs(s_axi_araddr))
      `OFS_CTRL: begin
        rd_d[4:0] = {waveform_mode_select_q, clock_source_select_q};
      end
      `OFS_COUNT: begin
        rd_d[7:0] = counter_value_q;            // see RULE1 RULE10
      end
      `OFS_COMPARE: begin
        rd_d[7:0] = is_pwm(waveform_mode_select_q) ? compare_buf_q
                                                   : compare_value_q;
      end
      `OFS_FLAGS: begin
        rd_d[1:0] = {overflow_flag_q, compare_match_flag_q};
      end
      default: begin
        rd_d = 32'h00000000;
      end
    endcase
  end

  wire rd_ok = (s_axi_araddr[31:4] == 28'h0000000) &&
               (s_axi_araddr[1:0] == 2'h0);

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid & ~s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_ok ? rd_d : 32'h00000000;
        s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

endmodule
`default_nettype wire

// ==== sim/tmr8_unit_checker.sv ====
// checker for tmr8_unit: bus answers, flag service, state after reset
// assumes it is bound to tmr8_unit and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
`include "tmr8_consts.vh"
module tmr8_unit_checker (
  input wire logic        core_clk_i,
  input wire logic        reset_n_i,
  input wire logic        match_ack_i,
  input wire logic        ovf_ack_i,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        compare_output_pin_o,
  input wire logic        match_irq_o,
  input wire logic        ovf_irq_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_rd_answer;
    s_axi_arvalid && !s_axi_rvalid |-> ##[1:4] s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read request not answered");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data dropped before taken");
  property p_rd_err;
    s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_rd_err: assert property (p_rd_err)
    else $error("refused read returned data");
  property p_rd_byte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_byte: assert property (p_rd_byte)
    else $error("upper read bits not zero");
  property p_wr_answer;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |-> ##[1:6] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write not answered");
  property p_aw_once;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_once: assert property (p_aw_once)
    else $error("write address taken twice");
  // outputs must not carry stale flag state across reset
  property p_rst_quiet;
    $rose(reset_n_i) |-> !match_irq_o && !ovf_irq_o && !compare_output_pin_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active right after reset");
  property p_match_srv;
    match_ack_i && match_irq_o |-> ##[1:3] !match_irq_o;
  endproperty
  a_match_srv: assert property (p_match_srv)
    else $error("match flag not cleared by service");
  property p_ovf_srv;
    ovf_ack_i && ovf_irq_o |-> ##[1:3] !ovf_irq_o;
  endproperty
  a_ovf_srv: assert property (p_ovf_srv)
    else $error("overflow flag not cleared by service");
endmodule
bind tmr8_unit tmr8_unit_checker u_chk (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
  .match_ack_i(match_ack_i), .ovf_ack_i(ovf_ack_i),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .compare_output_pin_o(compare_output_pin_o),
  .match_irq_o(match_irq_o), .ovf_irq_o(ovf_irq_o)
);
`default_nettype wire

// ==== sim/tmr8_unit_tb_top.sv ====
// testbench for tmr8_unit: axi4-lite tasks and ext-edge driven ticks
// assumes select 7 counts rising edges of ext_clk_i, one tick each
`timescale 1ns/100ps
`default_nettype none
`include "tmr8_consts.vh"
module tmr8_unit_tb_top;
  logic        core_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        ext_clk_i = 1'b0;
  logic        m_ack = 1'b0, o_ack = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, p;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        pin, m_irq, o_irq, top, bot;
  logic [1:0]  bresp, rresp;
  integer      err_total = 0, total_checks = 0, cyc = 0, i;
  // one row per waveform mode: start, ticks, end count, flags
  logic [1:0]  md [0:3] = '{`WGM_NORMAL, `WGM_PC_PWM, `WGM_CTC, `WGM_FAST_PWM};
  logic [7:0]  st [0:3] = '{8'hfe, 8'hfe, 8'h00, 8'hfe};
  integer      nt [0:3] = '{3, 2, 5, 3};
  logic [7:0]  ex [0:3] = '{8'h01, 8'hfe, 8'h01, 8'h01};
  logic [1:0]  ef [0:3] = '{2'h2, 2'h0, 2'h1, 2'h2};

  always #12.5 core_clk_i = ~core_clk_i;

  tmr8_unit uut (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ext_clk_i(ext_clk_i),
    .match_ack_i(m_ack), .ovf_ack_i(o_ack),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .compare_output_pin_o(pin), .match_irq_o(m_irq), .ovf_irq_o(o_irq),
    .top_o(top), .bottom_o(bot)
  );

  task chk(input string nm, input [31:0] e, input [31:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task wr(input [31:0] a, input [31:0] d, input [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge core_clk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge core_clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        done = 1'b1;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
      end
    end
  endtask

  // rready comes up only once the address is taken, so rdata must stand
  task rd(input [31:0] a, input [31:0] e, input [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge core_clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    while (!done) begin
      @(posedge core_clk_i);
      if (rvalid && rready) begin
        rready <= 1'b0;
        done = 1'b1;
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
      end
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        rready  <= 1'b1;
      end
    end
  endtask

  task ticks(input integer n);
    repeat (n) begin
      @(posedge core_clk_i);
      ext_clk_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      ext_clk_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
    end
    repeat (4) @(posedge core_clk_i);
  endtask

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      complete_run;
    end
  end

  initial begin
    repeat (4) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    for (i = 0; i < 4; i = i + 1)
      rd(i * 4, 32'h0, `RESP_OKAY);
    chk("bottom", 32'h1, {31'h0, bot});
    chk("top", 32'h0, {31'h0, top});
    wr(`OFS_COUNT, 32'h10, `RESP_OKAY);
    ticks(2);
    rd(`OFS_COUNT, 32'h10, `RESP_OKAY);
    rd(32'h10, 32'h0, `RESP_SLVERR);
    rd(32'h2, 32'h0, `RESP_SLVERR);
    wr(32'h10, 32'hff, `RESP_SLVERR);
    rd(`OFS_CTRL, 32'h0, `RESP_OKAY);
    wr(`OFS_COUNT, 32'hff, `RESP_OKAY);
    rd(`OFS_COUNT, 32'hff, `RESP_OKAY);
    chk("top", 32'h1, {31'h0, top});
    chk("bottom", 32'h0, {31'h0, bot});
    for (i = 0; i < 4; i = i + 1) begin
      wr(`OFS_CTRL, {27'h0, md[i], `CS_EXT_RISE}, `RESP_OKAY);
      wr(`OFS_COMPARE, 32'h3, `RESP_OKAY);
      wr(`OFS_COUNT, {24'h0, st[i]}, `RESP_OKAY);
      ticks(nt[i]);
      rd(`OFS_COUNT, {24'h0, ex[i]}, `RESP_OKAY);
      rd(`OFS_FLAGS, {30'h0, ef[i]}, `RESP_OKAY);
      chk("ovf_irq", {31'h0, ef[i][1]}, {31'h0, o_irq});
      m_ack <= 1'b1;
      o_ack <= 1'b1;
      @(posedge core_clk_i);
      m_ack <= 1'b0;
      o_ack <= 1'b0;
      rd(`OFS_FLAGS, 32'h0, `RESP_OKAY);
    end
    wr(`OFS_CTRL, {27'h0, `WGM_NORMAL, `CS_EXT_RISE}, `RESP_OKAY);
    wr(`OFS_COMPARE, 32'h5, `RESP_OKAY);
    wr(`OFS_COUNT, 32'h3, `RESP_OKAY);
    ticks(2);
    rd(`OFS_FLAGS, 32'h0, `RESP_OKAY);
    ticks(1);
    rd(`OFS_FLAGS, 32'h1, `RESP_OKAY);
    chk("match_irq", 32'h1, {31'h0, m_irq});
    wr(`OFS_FLAGS, 32'h1, `RESP_OKAY);
    rd(`OFS_FLAGS, 32'h0, `RESP_OKAY);
    wr(`OFS_COUNT, 32'h5, `RESP_OKAY);
    ticks(3);
    rd(`OFS_COUNT, 32'h8, `RESP_OKAY);
    rd(`OFS_FLAGS, 32'h0, `RESP_OKAY);
    p = pin;
    wr(`OFS_CTRL, {26'h0, 1'b1, `WGM_NORMAL, `CS_STOPPED}, `RESP_OKAY);
    repeat (3) @(posedge core_clk_i);
    chk("pin", {31'h0, ~p}, {31'h0, pin});
    complete_run;
  end
endmodule
`default_nettype wire
